// *** common/cspf_pkg.sv ***
// constants, register map and types of the cathode segment pattern finder
package cspf_pkg;
   // chamber geometry
   localparam int NUM_BOARDS   = 5;    // strip front-end boards per chamber
   localparam int NUM_LAYERS   = 6;
   localparam int TRIADS_BOARD = 8;    // triad channels per board per layer
   localparam int KEY_LAYER    = 2;    // third layer, counted from zero
   localparam int DI_PER_LAYER = NUM_BOARDS * TRIADS_BOARD;          // 40
   localparam int HS_PER_LAYER = 4 * DI_PER_LAYER;                   // 160
   localparam int NUM_CHAN     = NUM_LAYERS * DI_PER_LAYER;          // 240
   localparam int PIN_WIDTH    = NUM_BOARDS * NUM_LAYERS * TRIADS_BOARD;
   localparam int HS_PER_GROUP = 32;   // 16 strips
   localparam int DI_PER_GROUP = 8;    // 16 strips
   localparam int NUM_GROUPS   = HS_PER_LAYER / HS_PER_GROUP;
   // times in nanoseconds, rounded up to bunch crossings of the link clock
   localparam int BX_NS        = 25;
   localparam int STRETCH_NS   = 75;
   localparam int DELAY_NS     = 50;
   localparam logic [2:0] STRETCH_RST = 3'((STRETCH_NS + BX_NS - 1) / BX_NS);
   localparam logic [2:0] DELAY_RST   = 3'((DELAY_NS + BX_NS - 1) / BX_NS);
   localparam logic [2:0] PRETRIG_RST = 3'h2;
   localparam logic [2:0] MATCH_RST   = 3'h4;
   // register offsets
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_MASK0  = 12'h010;
   localparam int          NUM_MASKS  = 8;
   // control fields
   localparam int CTRL_PHASE = 0;      // 5 bits, one per board
   localparam int CTRL_N     = 5;
   localparam int CTRL_M     = 8;
   localparam int CTRL_STR   = 11;
   localparam int CTRL_DLY   = 14;
   localparam int CTRL_DI    = 17;
   localparam int CTRL_RAW   = 18;
   // n 2, m 4, stretch 3, delay 2; phase, di-strip and raw options off
   localparam logic [31:0] CTRL_RST = 32'({DELAY_RST, STRETCH_RST, MATCH_RST, PRETRIG_RST, 5'h00});
   // output word fields
   localparam int W_VALID = 23;
   localparam int W_PID   = 15;
   localparam int W_BEND  = 14;
   localparam int W_DI    = 13;
   localparam int W_POS   = 5;
   localparam int W_BX    = 0;
   localparam int W_WIDTH = 24;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_MATCH = 3'b100
   } cspf_seq_e;
endpackage : cspf_pkg

// *** src/cspf_top.sv ***
// cathode segment pattern finder with apb registers and raw hit pipeline
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cspf_top
   import cspf_pkg::*;
#(
   parameter int PIPE_DEPTH = 16
) (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   input  wire logic [11:0]          paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 linkClk,
   input  wire logic [PIN_WIDTH-1:0] compIn,
   input  wire logic                 l1aIn,
   input  wire logic [4:0]           l1aBxIn,
   output logic      [W_WIDTH-1:0]   lctWordA,
   output logic      [W_WIDTH-1:0]   lctWordB,
   output logic                      daqData,
   output logic                      daqValid
);
   localparam int PW = $clog2(PIPE_DEPTH);

   // pin bit of layer l, di-strip d
   function automatic int pinBit(input int l, input int d);
      return (d / TRIADS_BOARD) * NUM_LAYERS * TRIADS_BOARD + l * TRIADS_BOARD + d % TRIADS_BOARD;
   endfunction : pinBit

   // pattern number: type, layer count, straightness, bend
   function automatic logic [7:0] patNum(input logic isDi, input int cnt, input int s);
      return {~isDi, 3'(cnt), 3'(3 - (s < 0 ? -s : s)), (s > 0)};
   endfunction : patNum

   ////////////////////////////////////////////////////////////////////////////
   logic [PIN_WIDTH-1:0] riseQ1_q, riseQ2_q, fallQ1_q, fallQ2_q, sel_q;
   logic [2:0]           lclk_q;
   logic [2:0]           l1a_q;
   logic [4:0]           l1aBx1_q, l1aBx2_q;
   logic                 bxTick;
   logic [31:0]          ctrl_q;
   logic [255:0]         mask_q;
   logic [NUM_CHAN-1:0]  maskedBits;

   // rising-edge capture copy, two flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         riseQ1_q <= '0;
         riseQ2_q <= '0;
      end else begin
         riseQ1_q <= compIn;
         riseQ2_q <= riseQ1_q;
      end
   end

   // falling-edge capture copy, moved to the rising edge
   always_ff @(negedge clk_sys or negedge resetn) begin
      if (!resetn) fallQ1_q <= '0;
      else         fallQ1_q <= compIn;
   end

   // phase selection per board and final rising-edge register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fallQ2_q <= '0;
         sel_q    <= '0;
      end else begin
         fallQ2_q <= fallQ1_q;
         for (int b = 0; b < NUM_BOARDS; b++) begin
            for (int i = 0; i < NUM_LAYERS * TRIADS_BOARD; i++) begin
               sel_q[b * NUM_LAYERS * TRIADS_BOARD + i] <= ctrl_q[CTRL_PHASE + b] ?
                  fallQ2_q[b * NUM_LAYERS * TRIADS_BOARD + i] :
                  riseQ2_q[b * NUM_LAYERS * TRIADS_BOARD + i];
            end
         end
      end
   end

   // link clock and accept synchronisers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lclk_q   <= '0;
         l1a_q    <= '0;
         l1aBx1_q <= '0;
         l1aBx2_q <= '0;
      end else begin
         lclk_q   <= {lclk_q[1:0], linkClk};
         l1a_q    <= {l1a_q[1:0], l1aIn};
         l1aBx1_q <= l1aBxIn;
         l1aBx2_q <= l1aBx1_q;
      end
   end
   assign bxTick = lclk_q[1] & ~lclk_q[2];

   // channel masking in chamber order
   always_comb begin
      for (int l = 0; l < NUM_LAYERS; l++) begin
         for (int d = 0; d < DI_PER_LAYER; d++) begin
            maskedBits[l * DI_PER_LAYER + d] = sel_q[pinBit(l, d)] &
                                               ~mask_q[l * DI_PER_LAYER + d];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] triPh_q [NUM_CHAN];
   logic       triB1_q [NUM_CHAN];
   logic [2:0] hsCnt_q [NUM_LAYERS][HS_PER_LAYER];
   logic [HS_PER_LAYER-1:0] hsOn [NUM_LAYERS];
   logic [DI_PER_LAYER-1:0] dsOn [NUM_LAYERS];

   // triad decode and hit stretching, one step per bunch crossing
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            triPh_q[c] <= 2'h0;
            triB1_q[c] <= 1'b0;
         end
         for (int l = 0; l < NUM_LAYERS; l++)
            for (int k = 0; k < HS_PER_LAYER; k++) hsCnt_q[l][k] <= 3'h0;
      end else if (bxTick) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            case (triPh_q[c])
               2'h0:    triPh_q[c] <= maskedBits[c] ? 2'h1 : 2'h0;
               2'h1: begin
                  triB1_q[c] <= maskedBits[c];
                  triPh_q[c] <= 2'h2;
               end
               default: triPh_q[c] <= 2'h0;
            endcase
         end
         for (int l = 0; l < NUM_LAYERS; l++) begin
            for (int k = 0; k < HS_PER_LAYER; k++) begin
               if (triPh_q[l * DI_PER_LAYER + k / 4] == 2'h2 &&
                   {triB1_q[l * DI_PER_LAYER + k / 4], maskedBits[l * DI_PER_LAYER + k / 4]}
                   == 2'(k % 4))
                  hsCnt_q[l][k] <= ctrl_q[CTRL_STR +: 3];
               else if (hsCnt_q[l][k] != 3'h0)
                  hsCnt_q[l][k] <= hsCnt_q[l][k] - 3'h1;
            end
         end
      end
   end

   // stretched half-strip and di-strip bits
   always_comb begin
      for (int l = 0; l < NUM_LAYERS; l++) begin
         for (int k = 0; k < HS_PER_LAYER; k++) hsOn[l][k] = (hsCnt_q[l][k] != 3'h0);
         for (int d = 0; d < DI_PER_LAYER; d++) dsOn[l][d] = |hsOn[l][4 * d +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic       preTrig;
   logic [7:0] grpPid [NUM_GROUPS];
   logic [7:0] grpPos [NUM_GROUPS];
   logic       grpDi   [NUM_GROUPS];
   logic       grpBend [NUM_GROUPS];
   int         bestA, bestB;

   // pretrigger on di-strip layer coincidence over a three di-strip envelope
   always_comb begin
      int cnt;
      cnt     = 0;
      preTrig = 1'b0;
      for (int k = 0; k < DI_PER_LAYER; k++) begin
         cnt = 0;
         for (int l = 0; l < NUM_LAYERS; l++)
            if (dsOn[l][k] || (k > 0 && dsOn[l][k - 1]) ||
                (k < DI_PER_LAYER - 1 && dsOn[l][k + 1])) cnt++;
         if (cnt >= 1 && cnt >= int'(ctrl_q[CTRL_N +: 3])) preTrig = 1'b1;
      end
   end

   // pattern match over the whole chamber and best pick per 16 strips
   always_comb begin
      int cnt, idx;
      logic [7:0] pid;
      cnt = 0;
      idx = 0;
      pid = 8'h00;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         grpPid[g]  = 8'h00;
         grpPos[g]  = 8'h00;
         grpDi[g]   = 1'b0;
         grpBend[g] = 1'b0;
      end
      // keys run across board edges, so a boundary segment is one candidate
      for (int k = 0; k < HS_PER_LAYER; k++) begin
         for (int s = -1; s <= 1; s++) begin
            cnt = 0;
            for (int l = 0; l < NUM_LAYERS; l++) begin
               idx = k + s * (l - KEY_LAYER);
               if (idx >= 0 && idx < HS_PER_LAYER && hsOn[l][idx]) cnt++;
            end
            pid = patNum(1'b0, cnt, s);
            if (cnt >= 1 && cnt >= int'(ctrl_q[CTRL_M +: 3]) &&
                pid > grpPid[k / HS_PER_GROUP]) begin
               grpPid[k / HS_PER_GROUP]  = pid;
               grpPos[k / HS_PER_GROUP]  = 8'(k);
               grpDi[k / HS_PER_GROUP]   = 1'b0;
               grpBend[k / HS_PER_GROUP] = (s > 0);
            end
         end
      end
      // low-momentum di-strip patterns, only with the di-strip option on
      for (int k = 0; k < DI_PER_LAYER; k++) begin
         for (int s = -1; s <= 1; s++) begin
            cnt = 0;
            for (int l = 0; l < NUM_LAYERS; l++) begin
               idx = k + s * (l - KEY_LAYER);
               if (idx >= 0 && idx < DI_PER_LAYER && dsOn[l][idx]) cnt++;
            end
            pid = patNum(1'b1, cnt, s);
            if (ctrl_q[CTRL_DI] && cnt >= 1 && cnt >= int'(ctrl_q[CTRL_M +: 3]) &&
                pid > grpPid[k / DI_PER_GROUP]) begin
               grpPid[k / DI_PER_GROUP]  = pid;
               grpPos[k / DI_PER_GROUP]  = 8'(k);
               grpDi[k / DI_PER_GROUP]   = 1'b1;
               grpBend[k / DI_PER_GROUP] = (s > 0);
            end
         end
      end
   end

   // best two groups across the chamber
   always_comb begin
      bestA = NUM_GROUPS;
      bestB = NUM_GROUPS;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (grpPid[g] != 8'h00 && (bestA == NUM_GROUPS || grpPid[g] > grpPid[bestA])) begin
            bestB = bestA;
            bestA = g;
         end else if (grpPid[g] != 8'h00 &&
                      (bestB == NUM_GROUPS || grpPid[g] > grpPid[bestB])) begin
            bestB = g;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   cspf_seq_e   state_q;
   logic [2:0]  delayCnt_q;
   logic [11:0] bxCnt_q;
   logic        hitTick_q;
   logic [4:0]  bxSeg_q;
   logic [W_WIDTH-1:0] wordA_q, wordB_q;

   // bunch-crossing counter; stretched hits settle one clock after each tick,
   // so the coincidence is judged then and the delay ends before hits expire
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bxCnt_q   <= 12'h000;
         hitTick_q <= 1'b0;
      end else begin
         hitTick_q <= bxTick;
         if (bxTick) bxCnt_q <= bxCnt_q + 12'h001;
      end
   end

   // pretrigger, delay and match sequencer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q    <= ST_IDLE;
         delayCnt_q <= 3'h0;
         bxSeg_q    <= 5'h00;
      end else begin
         case (state_q)
            ST_IDLE: if (hitTick_q && preTrig) begin
               bxSeg_q    <= bxCnt_q[4:0];
               delayCnt_q <= ctrl_q[CTRL_DLY +: 3];
               state_q    <= ST_WAIT;
            end
            ST_WAIT: if (delayCnt_q == 3'h0) state_q <= ST_MATCH;
                     else if (bxTick) delayCnt_q <= delayCnt_q - 3'h1;
            ST_MATCH: state_q <= ST_IDLE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   // output words, valid for the one match cycle only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wordA_q <= '0;
         wordB_q <= '0;
      end else begin
         wordA_q <= '0;
         wordB_q <= '0;
         if (state_q == ST_MATCH && bestA < NUM_GROUPS)
            wordA_q <= {1'b1, grpPid[bestA], grpBend[bestA], grpDi[bestA],
                        grpPos[bestA], bxSeg_q};
         if (state_q == ST_MATCH && bestB < NUM_GROUPS)
            wordB_q <= {1'b1, grpPid[bestB], grpBend[bestB], grpDi[bestB],
                        grpPos[bestB], bxSeg_q};
      end
   end
   assign lctWordA = wordA_q;
   assign lctWordB = wordB_q;

   ////////////////////////////////////////////////////////////////////////////
   logic [NUM_CHAN-1:0] rawMem [PIPE_DEPTH];
   logic [PW-1:0]       wrPtr_q, rdWord_q;
   logic [7:0]          rdBit_q;
   logic                frozen_q, rdBusy_q, daq_q, daqV_q;
   logic [4:0]          frozenBx_q;
   logic                l1aEdge;
   assign l1aEdge = l1a_q[1] & ~l1a_q[2];

   // raw hit pipeline, written each crossing until frozen
   always_ff @(posedge clk_sys) begin
      if (bxTick && ctrl_q[CTRL_RAW] && !frozen_q) rawMem[wrPtr_q] <= maskedBits;
   end

   // freeze on segment, serial readout on a matching accept
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wrPtr_q    <= '0;
         rdWord_q   <= '0;
         rdBit_q    <= 8'h00;
         frozen_q   <= 1'b0;
         frozenBx_q <= 5'h00;
         rdBusy_q   <= 1'b0;
         daq_q      <= 1'b0;
         daqV_q     <= 1'b0;
      end else begin
         daqV_q <= rdBusy_q;
         daq_q  <= rdBusy_q ? rawMem[rdWord_q][rdBit_q] : 1'b0;
         if (bxTick && ctrl_q[CTRL_RAW] && !frozen_q) wrPtr_q <= wrPtr_q + 1'b1;
         if (state_q == ST_MATCH && bestA < NUM_GROUPS && ctrl_q[CTRL_RAW] && !frozen_q) begin
            frozen_q   <= 1'b1;
            frozenBx_q <= bxSeg_q;
         end
         if (!rdBusy_q && frozen_q && l1aEdge && l1aBx2_q == frozenBx_q) begin
            rdBusy_q <= 1'b1;
            rdWord_q <= wrPtr_q;
            rdBit_q  <= 8'h00;
         end else if (rdBusy_q) begin
            if (rdBit_q == 8'(NUM_CHAN - 1)) begin
               rdBit_q  <= 8'h00;
               rdWord_q <= rdWord_q + 1'b1;
               if (rdWord_q + 1'b1 == wrPtr_q) begin
                  rdBusy_q <= 1'b0;
                  frozen_q <= 1'b0;
               end
            end else begin
               rdBit_q <= rdBit_q + 8'h01;
            end
         end
      end
   end
   assign daqData  = daq_q;
   assign daqValid = daqV_q;

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;

   // apb slave, one wait state, writes land on the ready edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_q    <= CTRL_RST;
         mask_q    <= '0;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel & penable & ~pready_q;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         if (psel && penable && !pready_q) begin
            if (paddr == REG_CTRL)
               prdata_q <= {13'h0000, ctrl_q[18:0]};
            else if (paddr == REG_STATUS)
               prdata_q <= {19'h00000, bxSeg_q, 5'h00, state_q != ST_IDLE, rdBusy_q, frozen_q};
            else if (paddr >= REG_MASK0 && paddr < REG_MASK0 + 12'(4 * NUM_MASKS) &&
                     paddr[1:0] == 2'h0)
               prdata_q <= mask_q[32 * int'((paddr - REG_MASK0) >> 2) +: 32];
            else
               pslverr_q <= 1'b1;
         end
         if (psel && penable && pready_q && pwrite) begin
            if (paddr == REG_CTRL) ctrl_q <= {13'h0000, pwdata[18:0]};
            else if (paddr >= REG_MASK0 && paddr < REG_MASK0 + 12'(4 * NUM_MASKS) &&
                     paddr[1:0] == 2'h0)
               mask_q[32 * int'((paddr - REG_MASK0) >> 2) +: 32] <= pwdata;
         end
      end
   end
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_validPulse;
      @(posedge clk_sys) disable iff (!resetn) wordA_q[W_VALID] |=> !wordA_q[W_VALID];
   endproperty
   a_validPulse: assert property (p_validPulse) else $error("valid held too long");
   property p_validCause;
      @(posedge clk_sys) disable iff (!resetn)
         wordA_q[W_VALID] |-> $past(state_q) == ST_MATCH;
   endproperty
   a_validCause: assert property (p_validCause) else $error("valid outside match");
   property p_bxField;
      @(posedge clk_sys) disable iff (!resetn) wordA_q[W_VALID] |-> wordA_q[4:0] == bxSeg_q;
   endproperty
   a_bxField: assert property (p_bxField) else $error("bx field mismatch");
   property p_rankTwo;
      @(posedge clk_sys) disable iff (!resetn)
         wordB_q[W_VALID] |-> wordA_q[W_VALID] && wordA_q[W_PID +: 8] >= wordB_q[W_PID +: 8];
   endproperty
   a_rankTwo: assert property (p_rankTwo) else $error("second word outranks first");
   property p_diFlag;
      @(posedge clk_sys) disable iff (!resetn)
         wordA_q[W_VALID] |-> wordA_q[W_DI] == ~wordA_q[W_PID + 7];
   endproperty
   a_diFlag: assert property (p_diFlag) else $error("type flag disagrees");
   property p_posRange;
      @(posedge clk_sys) disable iff (!resetn)
         wordA_q[W_VALID] |-> wordA_q[W_POS +: 8] < (wordA_q[W_DI] ? 8'd40 : 8'd160);
   endproperty
   a_posRange: assert property (p_posRange) else $error("position out of range");
   property p_preTrig;
      @(posedge clk_sys) disable iff (!resetn)
         (state_q == ST_WAIT && $past(state_q) == ST_IDLE) |-> $past(preTrig && hitTick_q);
   endproperty
   a_preTrig: assert property (p_preTrig) else $error("wait without pretrigger");
   property p_readGate;
      @(posedge clk_sys) disable iff (!resetn)
         $rose(rdBusy_q) |-> $past(l1aEdge && frozen_q) ##1 daqValid;
   endproperty
   a_readGate: assert property (p_readGate) else $error("readout without accept");
   property p_freezeHold;
      @(posedge clk_sys) disable iff (!resetn)
         (frozen_q && !rdBusy_q) |=> frozen_q && $stable(wrPtr_q);
   endproperty
   a_freezeHold: assert property (p_freezeHold) else $error("pipeline not frozen");
   property p_apbReady;
      @(posedge clk_sys) disable iff (!resetn) (psel && penable && !pready_q) |=> pready_q;
   endproperty
   a_apbReady: assert property (p_apbReady) else $error("apb ready late");
   c_twoSeg: cover property (@(posedge clk_sys) wordA_q[W_VALID] && wordB_q[W_VALID]);
   c_diSeg:  cover property (@(posedge clk_sys) wordA_q[W_VALID] && wordA_q[W_DI]);
   c_readout: cover property (@(posedge clk_sys) $rose(rdBusy_q));
endmodule : cspf_top

// *** tb/cspf_fe_model.sv ***
// front-end board model that plays comparator triads onto the pins
`timescale 1ns/1ps
module cspf_fe_model
   import cspf_pkg::*;
(
   input  wire logic                 linkClk,
   output logic      [PIN_WIDTH-1:0] compIn
);
   //////////////////////////////
   // one triad per hit pin: hit, strip select, left or right, then idle low
   task automatic send(input logic [PIN_WIDTH-1:0] h, s, r);
      @(posedge linkClk) compIn <= h;
      @(posedge linkClk) compIn <= s & h;
      @(posedge linkClk) compIn <= r & h;
      @(posedge linkClk) compIn <= '0;
   endtask : send
   // pins start idle
   initial compIn = '0;
endmodule : cspf_fe_model

// *** tb/tb_top.sv ***
// self-checking bench of the cathode segment pattern finder
`timescale 1ns/1ps
module tb_top
   import cspf_pkg::*;
;
   localparam logic [31:0] NOBX = 32'hFFFF_FFE0;
   logic                 clk_sys, linkClk, pready, pslverr, daqData, daqValid, e;
   logic                 resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, l1aIn = 1'h0;
   logic [11:0]          paddr = 12'h0;
   logic [31:0]          pwdata = 32'h0, prdata, q;
   logic [4:0]           l1aBxIn = 5'h0;
   logic [PIN_WIDTH-1:0] compIn;
   logic [W_WIDTH-1:0]   lctWordA, lctWordB, wa, wb;
   int                   miscompares = 0, n_compared = 0, cyc = 0;
   //////////////////////////////
   // design and front-end model
   cspf_top #(.PIPE_DEPTH(4)) i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .linkClk(linkClk), .compIn(compIn), .l1aIn(l1aIn), .l1aBxIn(l1aBxIn),
      .lctWordA(lctWordA), .lctWordB(lctWordB), .daqData(daqData), .daqValid(daqValid)
   );
   cspf_fe_model i_fe (.linkClk(linkClk), .compIn(compIn));
   // system clock
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end
   // link clock, own phase
   initial begin
      linkClk = 1'h0;
      #137 forever #400 linkClk = ~linkClk;
   end
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   //////////////////////////////
   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, x);
      n_compared++;
      if (g !== x) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // apb transfer, answer taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk_sys) psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // wait for a valid word, then check it drops
   task automatic waitWord();
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (lctWordA[W_VALID] !== 1'h1 && n < 300);
      wa = lctWordA;
      wb = lctWordB;
      @(negedge clk_sys);
      if (n < 300) chk({31'h0, lctWordA[W_VALID]}, 32'h0);
   endtask : waitWord
   function automatic logic [PIN_WIDTH-1:0] pins(input int b, t, input logic [5:0] ly);
      logic [PIN_WIDTH-1:0] p;
      p = '0;
      for (int l = 0; l < NUM_LAYERS; l++) p[b*48+l*8+t] = ly[l];
      return p;
   endfunction : pins
   function automatic logic [31:0] expWord(input logic [7:0] pid, pos);
      return {8'h0, 1'h1, pid, 2'h0, pos, 5'h0};
   endfunction : expWord
   //////////////////////////////
   // scenarios
   task automatic tRegs();
      apb(1'h0, REG_CTRL, 32'h0, q, e);
      chk(q, CTRL_RST);
      apb(1'h0, 12'h0FC, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      apb(1'h1, REG_MASK0 + 12'h4, 32'h0000_00A5, q, e);
      apb(1'h0, REG_MASK0 + 12'h4, 32'h0, q, e);
      chk(q, 32'h0000_00A5);
      apb(1'h1, REG_MASK0 + 12'h4, 32'h0, q, e);
   endtask : tRegs
   task automatic tTwo();
      i_fe.send(pins(1, 3, 6'h0F) | pins(3, 5, 6'h1F), pins(1, 3, 6'h0F), pins(3, 5, 6'h1F));
      waitWord();
      chk({8'h0, wa} & NOBX, expWord(8'hD6, 8'h75));
      chk({8'h0, wb} & NOBX, expWord(8'hC6, 8'h2E));
      chk({27'h0, wa[4:0]}, {27'h0, wb[4:0]});
   endtask : tTwo
   task automatic tGroup();
      i_fe.send(pins(1, 0, 6'h0F) | pins(1, 2, 6'h1F), '0, '0);
      waitWord();
      chk({8'h0, wa} & NOBX, expWord(8'hD6, 8'h28));
      chk({31'h0, wb[W_VALID]}, 32'h0);
   endtask : tGroup
   task automatic tMask();
      apb(1'h1, REG_MASK0, 32'h0000_0100, q, e);
      i_fe.send(pins(1, 0, 6'h0F), '0, '0);
      waitWord();
      chk({31'h0, wa[W_VALID]}, 32'h0);
      apb(1'h1, REG_MASK0, 32'h0, q, e);
   endtask : tMask
   // strongly bending track, only the di-strip set can find it
   task automatic tDi();
      apb(1'h1, REG_CTRL, CTRL_RST | 32'h0002_0000, q, e);
      i_fe.send(pins(1, 2, 6'h01) | pins(1, 3, 6'h02) | pins(1, 4, 6'h04) | pins(1, 5, 6'h08),
                '0, '0);
      waitWord();
      chk({8'h0, wa} & NOBX, expWord(8'h45, 8'h0C) | 32'h0000_6000);
      apb(1'h1, REG_CTRL, CTRL_RST, q, e);
   endtask : tDi
   task automatic tRaw();
      int k, j;
      k = 0;
      j = 0;
      apb(1'h1, REG_CTRL, CTRL_RST | 32'h0004_001F, q, e);
      i_fe.send(pins(2, 4, 6'h3F), pins(2, 4, 6'h3F), pins(2, 4, 6'h3F));
      waitWord();
      chk({8'h0, wa} & NOBX, expWord(8'hE6, 8'h53));
      apb(1'h0, REG_STATUS, 32'h0, q, e);
      chk({31'h0, q[0]}, 32'h1);
      chk({27'h0, q[12:8]}, {27'h0, wa[4:0]});
      chk({31'h0, daqValid}, 32'h0);
      l1aBxIn <= q[12:8];
      @(posedge clk_sys) l1aIn <= 1'h1;
      repeat (4) @(posedge clk_sys);
      l1aIn <= 1'h0;
      repeat (1200) begin
         @(negedge clk_sys);
         if (daqValid === 1'h1) k++;
         if (daqValid === 1'h1 && daqData === 1'h1) j++;
      end
      chk(32'(k), 32'h3C0);
      // frozen window holds the select and side bits of six layers
      chk(32'(j), 32'hC);
      apb(1'h0, REG_STATUS, 32'h0, q, e);
      chk({31'h0, q[0]}, 32'h0);
   endtask : tRaw
   // main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'h1;
      tRegs();
      tTwo();
      tGroup();
      tMask();
      tDi();
      tRaw();
      end_of_test();
   end
endmodule : tb_top
